// ===== design/timer_run_gate.sv
// Run bits of one timer and the count enables of its high and low bytes
`timescale 1ns/100ps
module timer_run_gate #(
    parameter bit HAS_SPLIT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Strobes
    input wire logic run_set,
    input wire logic run_clr,
    input wire logic low_set,
    input wire logic low_clr,
    // Mode
    input wire logic split,
    // State and enables
    output logic run_q,
    output logic low_run_q,
    output logic count_en_high,
    output logic count_en_low
);

    // Main run bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (run_set) begin
            run_q <= 1'b1;
        end else if (run_clr) begin
            run_q <= 1'b0;
        end
    end

    // Low-half run bit, held only where the timer can split
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run_q <= 1'b0;
        end else if (HAS_SPLIT && low_set) begin
            low_run_q <= 1'b1;
        end else if (HAS_SPLIT && low_clr) begin
            low_run_q <= 1'b0;
        end
    end

    // Split: low bit gates low byte, main bit gates high byte
    always_comb begin
        count_en_high = run_q;
        if (HAS_SPLIT && split) begin
            count_en_low = low_run_q;
        end else begin
            count_en_low = run_q;
        end
    end

endmodule

// ===== design/timer_sync_ctrl.sv
// Global synchronous start, reload and stop control for timers 0 to 4
`timescale 1ns/100ps
`include "timer_sync_defines.svh"

// Function
// - Start bits 4..0 set the run bits of timers 4..0 together.
// - Start bits 7..5 set low-half run of timers 4..2, only in split mode.
// - Every trigger bit clears itself by hardware after a one is written.
// - Writing zero to any trigger bit does nothing.
// - Reload bits 0 and 1 reload both count bytes of timer 0 or 1.
// - Reload bits 4..2 reload both bytes unsplit, high byte only when split.
// - Reload bits 7..5 reload the low byte of timers 4..2, only when split.
// - Forced reloads of timers 2..4 are ignored in capture mode.
// - Stop bits 4..0 clear the run bits of timers 4..0 together.
// - Stop bits 7..5 clear low-half run of timers 4..2, only in split mode.
// - In split mode low-half run gates low byte, main run gates high byte.
// - Low-half run bit starts the low byte at one, stops it at zero.
module timer_sync_ctrl #(
    parameter int TIMERS = `TSC_TIMERS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Special function register access
    input wire timer_sync_pkg::sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    // Timer mode inputs
    input wire logic [TIMERS-1:0] split_mode,
    input wire logic [TIMERS-1:0] capture_mode,
    // Strobes to the timers
    output timer_sync_pkg::strobe_type strobe,
    // Run state and count enables
    output logic [TIMERS-1:0] run_bit,
    output logic [TIMERS-1:`TSC_SPLIT_FIRST] low_half_run,
    output logic [TIMERS-1:0] count_en_high,
    output logic [TIMERS-1:0] count_en_low
);

    timer_sync_pkg::trig_kind_type wr_kind;
    timer_sync_pkg::trig_kind_type rd_kind;
    timer_sync_pkg::strobe_type strobe_d;
    timer_sync_pkg::strobe_type strobe_q;
    logic [7:0] start_trig_q;
    logic [7:0] reload_trig_q;
    logic [7:0] stop_trig_q;
    logic [7:0] rdata_q;
    logic [TIMERS-1:0] low_run_all;
    logic [4:0] whole_bits;
    logic [4:0] low_bits;
    logic [4:0] settle_q;

    // Which trigger register a page and address select
    function automatic timer_sync_pkg::trig_kind_type decode(input logic [7:0] addr, input logic [3:0] page);
        timer_sync_pkg::trig_kind_type kind;
        kind = timer_sync_pkg::TRIG_NONE;
        if (addr == `TSC_TRIG_ADDR) begin
            case (page)
                `TSC_START_PAGE: kind = timer_sync_pkg::TRIG_START;
                `TSC_RELOAD_PAGE: kind = timer_sync_pkg::TRIG_RELOAD;
                `TSC_STOP_PAGE: kind = timer_sync_pkg::TRIG_STOP;
                default: kind = timer_sync_pkg::TRIG_NONE;
            endcase
        end
        return kind;
    endfunction

    // Spread the low-half field onto timer positions 4..2
    function automatic logic [4:0] low_field(input logic [7:0] data);
        return {data[`TSC_LOW_MSB:`TSC_LOW_LSB], 2'h0};
    endfunction

    always_comb begin
        wr_kind = sfr_req.wr ? decode(sfr_req.addr, sfr_req.page) : timer_sync_pkg::TRIG_NONE;
        rd_kind = sfr_req.rd ? decode(sfr_req.addr, sfr_req.page) : timer_sync_pkg::TRIG_NONE;
        whole_bits = sfr_req.wdata[`TSC_WHOLE_MSB:`TSC_WHOLE_LSB];
        low_bits = low_field(sfr_req.wdata) & split_mode[4:0];
    end

    // Strobe decode from the written value; zeros never produce a strobe
    always_comb begin
        strobe_d = '0;
        case (wr_kind)
            timer_sync_pkg::TRIG_START: begin
                strobe_d.run_set = whole_bits;
                strobe_d.low_set = low_bits;
            end
            timer_sync_pkg::TRIG_STOP: begin
                strobe_d.run_clr = whole_bits;
                strobe_d.low_clr = low_bits;
            end
            timer_sync_pkg::TRIG_RELOAD: begin
                strobe_d.reload_high[1:0] = whole_bits[1:0];
                strobe_d.reload_low[1:0] = whole_bits[1:0];
                strobe_d.reload_high[4:2] = whole_bits[4:2] & ~capture_mode[4:2];
                strobe_d.reload_low[4:2] = (whole_bits[4:2] & ~split_mode[4:2]
                    | low_bits[4:2]) & ~capture_mode[4:2];
            end
            default: strobe_d = '0;
        endcase
    end

    // One registered strobe word so every selected timer acts on one edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_q <= '0;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    assign strobe = strobe_q;

    // Trigger images: hold the written ones for one cycle, then self-clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_trig_q <= `TSC_TRIG_RESET;
        end else if (wr_kind == timer_sync_pkg::TRIG_START) begin
            start_trig_q <= sfr_req.wdata;
        end else begin
            start_trig_q <= `TSC_TRIG_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_trig_q <= `TSC_TRIG_RESET;
        end else if (wr_kind == timer_sync_pkg::TRIG_RELOAD) begin
            reload_trig_q <= sfr_req.wdata;
        end else begin
            reload_trig_q <= `TSC_TRIG_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_trig_q <= `TSC_TRIG_RESET;
        end else if (wr_kind == timer_sync_pkg::TRIG_STOP) begin
            stop_trig_q <= sfr_req.wdata;
        end else begin
            stop_trig_q <= `TSC_TRIG_RESET;
        end
    end

    // Registered read data; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            case (rd_kind)
                timer_sync_pkg::TRIG_START: rdata_q <= start_trig_q;
                timer_sync_pkg::TRIG_RELOAD: rdata_q <= reload_trig_q;
                timer_sync_pkg::TRIG_STOP: rdata_q <= stop_trig_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;

    // Run bits and count enables per timer
    for (genvar g = 0; g < TIMERS; g++) begin : gen_timer
        timer_run_gate #(
            .HAS_SPLIT(g >= `TSC_SPLIT_FIRST)
        ) u_gate (
            .clk(clk),
            .rst(rst),
            .run_set(strobe_q.run_set[g]),
            .run_clr(strobe_q.run_clr[g]),
            .low_set(strobe_q.low_set[g]),
            .low_clr(strobe_q.low_clr[g]),
            .split(split_mode[g]),
            .run_q(run_bit[g]),
            .low_run_q(low_run_all[g]),
            .count_en_high(count_en_high[g]),
            .count_en_low(count_en_low[g])
        );
    end

    assign low_half_run = low_run_all[TIMERS-1:`TSC_SPLIT_FIRST];

    // Cycles since the last write, for settled-read checks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_q <= 5'h00;
        end else if (sfr_req.wr) begin
            settle_q <= 5'h00;
        end else if (settle_q != 5'h1F) begin
            settle_q <= settle_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_start_whole;
        (wr_kind == timer_sync_pkg::TRIG_START) |=>
            (strobe.run_set == $past(sfr_req.wdata[4:0])) ##1 ((run_bit & $past(sfr_req.wdata[4:0], 2)) ==
            $past(sfr_req.wdata[4:0], 2));
    endproperty
    a_start_whole: assert property (p_start_whole) else $error("start write did not set run bits");

    property p_start_low;
        (wr_kind == timer_sync_pkg::TRIG_START) |=>
            strobe.low_set[4:2] == ($past(sfr_req.wdata[7:5]) & $past(split_mode[4:2]));
    endproperty
    a_start_low: assert property (p_start_low) else $error("low-half start strobe wrong");

    property p_self_clear;
        (start_trig_q != 8'h00 || reload_trig_q != 8'h00 || stop_trig_q != 8'h00) && !sfr_req.wr |=>
            (start_trig_q == 8'h00 && reload_trig_q == 8'h00 && stop_trig_q == 8'h00);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("trigger bit did not self-clear");

    property p_no_write_no_strobe;
        !sfr_req.wr |=> (strobe == '0);
    endproperty
    a_no_write_no_strobe: assert property (p_no_write_no_strobe) else $error("strobe without write");

    property p_reload_low_timers;
        (wr_kind == timer_sync_pkg::TRIG_RELOAD) |=>
            strobe.reload_high[1:0] == $past(sfr_req.wdata[1:0]) && strobe.reload_low[1:0] == $past(sfr_req.wdata[1:0]);
    endproperty
    a_reload_low_timers: assert property (p_reload_low_timers) else $error("timer 0/1 reload wrong");

    property p_reload_split_high;
        (wr_kind == timer_sync_pkg::TRIG_RELOAD) && sfr_req.wdata[2] && !sfr_req.wdata[5] && !capture_mode[2] |=>
            strobe.reload_high[2] && (strobe.reload_low[2] == !$past(split_mode[2]));
    endproperty
    a_reload_split_high: assert property (p_reload_split_high) else $error("timer 2 reload wrong");

    property p_reload_low_half;
        (wr_kind == timer_sync_pkg::TRIG_RELOAD) && sfr_req.wdata[7] && split_mode[4] && !capture_mode[4] |=>
            strobe.reload_low[4];
    endproperty
    a_reload_low_half: assert property (p_reload_low_half) else $error("timer 4 low reload missing");

    property p_capture_blocks;
        (wr_kind == timer_sync_pkg::TRIG_RELOAD) && capture_mode[3] |=>
            !strobe.reload_high[3] && !strobe.reload_low[3];
    endproperty
    a_capture_blocks: assert property (p_capture_blocks) else $error("reload in capture mode");

    property p_stop_whole;
        (wr_kind == timer_sync_pkg::TRIG_STOP) |=> ##1 ((run_bit & $past(sfr_req.wdata[4:0], 2)) == 5'h00);
    endproperty
    a_stop_whole: assert property (p_stop_whole) else $error("stop write did not clear run bits");

    property p_stop_low;
        (wr_kind == timer_sync_pkg::TRIG_STOP) && sfr_req.wdata[7] && split_mode[4] |=> ##1 !low_half_run[4];
    endproperty
    a_stop_low: assert property (p_stop_low) else $error("low-half stop failed");

    property p_split_gating;
        split_mode[4] |-> count_en_low[4] == low_half_run[4] && count_en_high[4] == run_bit[4];
    endproperty
    a_split_gating: assert property (p_split_gating) else $error("split gating wrong");

    property p_settled_read;
        sfr_req.rd && decode(sfr_req.addr, sfr_req.page) != timer_sync_pkg::TRIG_NONE && settle_q >= 5'h02 |=>
            sfr_rdata == 8'h00;
    endproperty
    a_settled_read: assert property (p_settled_read) else $error("trigger read not zero");

    c_start_all: cover property ((wr_kind == timer_sync_pkg::TRIG_START) && sfr_req.wdata == 8'hFF);
    c_reload_split: cover property ((wr_kind == timer_sync_pkg::TRIG_RELOAD) && split_mode[3] && sfr_req.wdata[6]);
    c_stop_after_start: cover property (strobe.run_set[0] ##[1:20] strobe.run_clr[0]);
    c_low_stop: cover property (strobe.low_clr[2]);
    c_capture_refused: cover property ((wr_kind == timer_sync_pkg::TRIG_RELOAD) && capture_mode[4] && sfr_req.wdata[4]);

    property p_zero_write;
        (wr_kind != timer_sync_pkg::TRIG_NONE) && sfr_req.wdata == 8'h00 |=> strobe == '0;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write made a strobe");

    property p_reload_unsplit_both;
        (wr_kind == timer_sync_pkg::TRIG_RELOAD) && sfr_req.wdata[4] && !split_mode[4] && !capture_mode[4] |=>
            strobe.reload_high[4] && strobe.reload_low[4];
    endproperty
    a_reload_unsplit_both: assert property (p_reload_unsplit_both) else $error("unsplit reload missed a byte");

    property p_low_set;
        strobe.low_set[4] |=> low_half_run[4];
    endproperty
    a_low_set: assert property (p_low_set) else $error("low-half run not set");

    property p_low_clr;
        strobe.low_clr[4] && !strobe.low_set[4] |=> !low_half_run[4];
    endproperty
    a_low_clr: assert property (p_low_clr) else $error("low-half run not cleared");

    property p_unsplit_low;
        !split_mode[3] |-> count_en_low[3] == run_bit[3];
    endproperty
    a_unsplit_low: assert property (p_unsplit_low) else $error("unsplit low byte not gated by run bit");

    property p_run_same_edge;
        strobe.run_set != 5'h00 |=> (run_bit & $past(strobe.run_set)) == $past(strobe.run_set);
    endproperty
    a_run_same_edge: assert property (p_run_same_edge) else $error("selected timers did not start together");

    property p_read_image;
        rd_kind == timer_sync_pkg::TRIG_STOP |=> sfr_rdata == $past(stop_trig_q);
    endproperty
    a_read_image: assert property (p_read_image) else $error("stop register read wrong");

endmodule

// ===== design/timer_sync_defines.svh
// Offsets, pages, field positions and reset values of the timer sync control block
`ifndef TIMER_SYNC_DEFINES_SVH
`define TIMER_SYNC_DEFINES_SVH

`define TSC_TRIG_ADDR 8'h95
`define TSC_START_PAGE 4'h1
`define TSC_RELOAD_PAGE 4'h2
`define TSC_STOP_PAGE 4'h3
`define TSC_TRIG_RESET 8'h00
`define TSC_WHOLE_LSB 0
`define TSC_WHOLE_MSB 4
`define TSC_LOW_LSB 5
`define TSC_LOW_MSB 7
`define TSC_SPLIT_FIRST 2
`define TSC_TIMERS 5

`endif

// ===== design/timer_sync_pkg.sv
// Types shared by the timer sync control block
package timer_sync_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] page;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        logic [4:0] run_set;
        logic [4:0] run_clr;
        logic [4:0] low_set;
        logic [4:0] low_clr;
        logic [4:0] reload_high;
        logic [4:0] reload_low;
    } strobe_type;

    typedef enum logic [1:0] {
        TRIG_NONE = 2'b00,
        TRIG_START = 2'b01,
        TRIG_RELOAD = 2'b10,
        TRIG_STOP = 2'b11
    } trig_kind_type;

endpackage

// ===== tb/testbench.sv
// Self-checking testbench of the timer sync control block
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [3:0] page;
        logic [7:0] data;
        logic [4:0] split;
        logic [4:0] cap;
    } row_type;

    logic clk;
    logic rst;
    timer_sync_pkg::sfr_req_type sfr_req;
    logic [7:0] sfr_rdata;
    logic [4:0] split_mode;
    logic [4:0] capture_mode;
    timer_sync_pkg::strobe_type strobe;
    timer_sync_pkg::strobe_type exp_s;
    logic [4:0] run_bit;
    logic [4:0] count_en_high;
    logic [4:0] count_en_low;
    logic [4:0] exp_run;
    logic [4:2] low_half_run;
    logic [4:2] exp_low;
    int error_cnt;
    int total_checks;
    // Page, write data, split mode, capture mode
    row_type rows [13] = '{
        '{4'h1, 8'hFF, 5'h1C, 5'h00}, '{4'h3, 8'hE0, 5'h00, 5'h00}, '{4'h3, 8'h15, 5'h1C, 5'h00},
        '{4'h3, 8'hA0, 5'h1C, 5'h00}, '{4'h2, 8'hFF, 5'h1C, 5'h00}, '{4'h2, 8'hFF, 5'h00, 5'h00},
        '{4'h2, 8'hFF, 5'h14, 5'h08}, '{4'h2, 8'h00, 5'h1C, 5'h00}, '{4'h1, 8'h60, 5'h08, 5'h00},
        '{4'h4, 8'hFF, 5'h1C, 5'h00}, '{4'h3, 8'hFF, 5'h1C, 5'h00}, '{4'h1, 8'h20, 5'h04, 5'h00},
        '{4'h2, 8'hF3, 5'h1C, 5'h1C}
    };

    timer_sync_ctrl dut (
        .clk(clk),
        .rst(rst),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .split_mode(split_mode),
        .capture_mode(capture_mode),
        .strobe(strobe),
        .run_bit(run_bit),
        .low_half_run(low_half_run),
        .count_en_high(count_en_high),
        .count_en_low(count_en_low)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    // Expected strobes of one write, worked out per bit
    function automatic timer_sync_pkg::strobe_type model(input row_type r);
        logic [4:0] sp;
        logic [4:0] lo;
        logic [4:0] ok;
        sp = r.split & 5'h1C;
        lo = {r.data[7:5], 2'h0} & sp;
        ok = ~(r.cap & 5'h1C);
        model = '0;
        if (r.page == 4'h1) begin
            model.run_set = r.data[4:0];
            model.low_set = lo;
        end
        if (r.page == 4'h3) begin
            model.run_clr = r.data[4:0];
            model.low_clr = lo;
        end
        if (r.page == 4'h2) begin
            model.reload_high = r.data[4:0] & ok;
            model.reload_low = ((r.data[4:0] & ~sp) | lo) & ok;
        end
    endfunction

    task automatic write(input row_type r, input logic [7:0] addr);
        logic [4:0] sp;
        @(posedge clk);
        sfr_req <= '{addr, r.page, 1'b1, 1'b0, r.data};
        split_mode <= r.split;
        capture_mode <= r.cap;
        @(posedge clk);
        sfr_req.wr <= 1'b0;
        #1;
        exp_s = (addr == 8'h95) ? model(r) : '0;
        check(strobe, exp_s, "strobe");
        exp_run = (exp_run | exp_s.run_set) & ~exp_s.run_clr;
        exp_low = (exp_low | exp_s.low_set[4:2]) & ~exp_s.low_clr[4:2];
        sp = r.split & 5'h1C;
        @(posedge clk);
        #1;
        check(strobe, 64'h0, "strobe pulse width");
        check(run_bit, exp_run, "run bits");
        check(low_half_run, exp_low, "low half run");
        check(count_en_high, exp_run, "high enable");
        check(count_en_low, (exp_run & ~sp) | ({exp_low, 2'h0} & sp), "low enable");
    endtask

    task automatic read(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        sfr_req <= '{addr, page, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        #1;
        check(sfr_rdata, exp, "read data");
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        error_cnt++;
        $display("[FAIL] %0t run limit reached", $time);
        summarize();
    end

    initial begin
        rst = 1'b1;
        sfr_req = '0;
        split_mode = 5'h00;
        capture_mode = 5'h00;
        error_cnt = 0;
        total_checks = 0;
        exp_run = 5'h00;
        exp_low = 3'h0;
        repeat (4) @(posedge clk);
        #1;
        check({strobe, run_bit, low_half_run, sfr_rdata}, 64'h0, "outputs in reset");
        @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            read(4'(i + 1), 8'h95, 8'h00);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            write(rows[i], 8'h95);
        end
        $display("test table done");
        // Wrong address on a valid page does nothing
        write('{4'h1, 8'hFF, 5'h1C, 5'h00}, 8'h96);
        read(4'h1, 8'h96, 8'h00);
        read(4'h0, 8'h95, 8'h00);
        $display("test unmapped done");
        // Start then stop on back-to-back edges, then read the stop image while it stands
        @(posedge clk);
        sfr_req <= '{8'h95, 4'h1, 1'b1, 1'b0, 8'h03};
        @(posedge clk);
        sfr_req <= '{8'h95, 4'h3, 1'b1, 1'b1, 8'h01};
        #1;
        check(strobe.run_set, 5'h03, "start strobe");
        @(posedge clk);
        sfr_req <= '{8'h95, 4'h3, 1'b0, 1'b1, 8'h00};
        #1;
        check(sfr_rdata, 8'h00, "read in write cycle");
        check(strobe.run_clr, 5'h01, "stop strobe");
        check(strobe.run_set, 5'h00, "start strobe gone");
        check(run_bit, (exp_run | 5'h03), "run after start");
        @(posedge clk);
        sfr_req <= '0;
        #1;
        check(sfr_rdata, 8'h01, "stop image while it stands");
        check(run_bit, (exp_run | 5'h03) & 5'h1E, "run after stop");
        read(4'h3, 8'h95, 8'h00);
        read(4'h1, 8'h95, 8'h00);
        $display("test back to back done");
        // Reset in mid-run clears the run state, and the first write after it is taken
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        check({run_bit, low_half_run, strobe}, 64'h0, "state after second reset");
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check({run_bit, low_half_run, strobe, sfr_rdata}, 64'h0, "outputs at release");
        exp_run = 5'h00;
        exp_low = 3'h0;
        write('{4'h1, 8'hFF, 5'h1C, 5'h00}, 8'h95);
        $display("test second reset done");
        summarize();
    end
endmodule
